// ### core/pcio_pkg.sv
// shared types and constants of the pc i/o emulation block
package pcio_pkg;
    // printer port register indices (data, status, control)
    localparam logic [1:0] PCIO_PRN_DATA = 2'h0;
    localparam logic [1:0] PCIO_PRN_STAT = 2'h1;
    localparam logic [1:0] PCIO_PRN_CTRL = 2'h2;
    localparam logic [7:0] PCIO_PRN_STAT_RST = 8'hdf;
    localparam logic [7:0] PCIO_PRN_CTRL_RST = 8'h0c;
    // interrupt source bit positions
    localparam int PCIO_IRQ_PRN = 0;
    localparam int PCIO_IRQ_MBX_HOST = 1;
    localparam int PCIO_IRQ_MBX_CARD = 2;
    localparam int PCIO_IRQ_KBD = 3;
    localparam int PCIO_NIRQ = 4;
    localparam logic [3:0] PCIO_MASK_RST = 4'h0;
    // mailbox owners
    localparam logic [1:0] PCIO_OWN_NONE = 2'h0;
    localparam logic [1:0] PCIO_OWN_CARD = 2'h1;
    localparam logic [1:0] PCIO_OWN_HOST = 2'h2;
    // serial link timing: 40 us half period of the keyboard clock
    localparam int PCIO_CLK_HZ = 20000000;
    localparam int PCIO_HALF_US = 40;
    localparam int PCIO_HALF_CYC = PCIO_CLK_HZ / 1000000 * PCIO_HALF_US;
    localparam logic [10:0] PCIO_HALF_CNT = 11'(PCIO_HALF_CYC - 1);
    localparam logic [3:0] PCIO_FRAME_BITS = 4'hb;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] idx;
        logic [7:0] wdata;
    } pcio_prn_req_type;

    typedef struct packed {
        logic dimm_present;
        logic [3:0] audio_sw;
        logic [7:0] isa_irq_route;
    } pcio_cfg_type;

    typedef struct packed {
        logic valid;
        logic chan;
        logic [7:0] code;
    } pcio_key_type;

    typedef enum logic [1:0] {
        PCIO_SER_IDLE = 2'b00,
        PCIO_SER_LOW = 2'b01,
        PCIO_SER_HIGH = 2'b10
    } pcio_ser_state_type;
endpackage

// ### core/pcio_ser_tx.sv
// serial clock and bit stream generator for one keyboard or mouse frame
`timescale 1ns/1ps
module pcio_ser_tx
    import pcio_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [7:0] code,
    output logic busy,
    output logic ser_clk_q,
    output logic ser_dat_q
);
    pcio_ser_state_type state_q;
    logic [10:0] tick_q;
    logic [3:0] bit_q;
    logic [10:0] frame_q;
    wire tick_done = (tick_q == PCIO_HALF_CNT);
    wire last_bit = (bit_q == PCIO_FRAME_BITS - 4'h1);
    // start 0, data lsb first, odd parity, stop 1
    wire [10:0] frame_d = {1'b1, ~^code, code, 1'b0};

    assign busy = (state_q != PCIO_SER_IDLE);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_q <= PCIO_SER_IDLE;
            tick_q <= 11'h000;
            bit_q <= 4'h0;
            frame_q <= 11'h7ff;
            ser_clk_q <= 1'b1;
            ser_dat_q <= 1'b1;
        end else begin
            tick_q <= (tick_done || state_q == PCIO_SER_IDLE) ? 11'h000 : tick_q + 11'h001;
            case (state_q)
                PCIO_SER_IDLE: begin
                    if (start) begin
                        frame_q <= frame_d;
                        ser_dat_q <= frame_d[0];
                        bit_q <= 4'h0;
                        state_q <= PCIO_SER_HIGH;
                    end
                end
                PCIO_SER_HIGH: begin
                    // data is set up a full half period before the falling edge
                    if (tick_done) begin
                        ser_clk_q <= 1'b0;
                        state_q <= PCIO_SER_LOW;
                    end
                end
                PCIO_SER_LOW: begin
                    if (tick_done) begin
                        ser_clk_q <= 1'b1;
                        if (last_bit) begin
                            ser_dat_q <= 1'b1;
                            state_q <= PCIO_SER_IDLE;
                        end else begin
                            ser_dat_q <= frame_q[bit_q + 4'h1];
                            bit_q <= bit_q + 4'h1;
                            state_q <= PCIO_SER_HIGH;
                        end
                    end
                end
                default: state_q <= PCIO_SER_IDLE;
            endcase
        end
    end
endmodule

// ### core/pcio_top.sv
// pc i/o emulation: virtual printer port, keyboard/mouse emulator, mailbox, autoconfig
// Function
// - full printer port register set present
// - every printer register access interrupts host
// - no physical printer handshake pins
// - printer port output only
// - emulator makes serial clock and data
// - same protocol on keyboard and mouse
// - mailbox: two data, one command register
// - grant sets direction; only owner writes
// - message delivery interrupts the receiver
// - configuration sensed and applied at reset
// - 64 data bits, 32-bit command
// - interrupt status and mask registers
`timescale 1ns/1ps
module pcio_top
    import pcio_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    // card processor printer port access
    input pcio_prn_req_type prn_req,
    output logic [7:0] prn_rdata_q,
    // host side printer data readout
    output logic [7:0] host_prn_data_q,
    output logic [7:0] host_prn_ctrl_q,
    // key and mouse codes from the host
    input pcio_key_type key_in,
    output logic key_ready,
    output logic kbd_clk_q,
    output logic kbd_dat_q,
    output logic mse_clk_q,
    output logic mse_dat_q,
    // mailbox, card side
    input wire logic card_req,
    input wire logic card_release,
    input wire logic card_wr,
    input wire logic [1:0] card_sel,
    input wire logic [31:0] card_wdata,
    output logic card_grant,
    // mailbox, host side
    input wire logic host_req,
    input wire logic host_release,
    input wire logic host_wr,
    input wire logic [1:0] host_sel,
    input wire logic [31:0] host_wdata,
    output logic host_grant,
    output logic [63:0] mbx_data_q,
    output logic [31:0] mbx_cmd_q,
    // interrupt status and mask
    input wire logic [3:0] irq_mask_wdata,
    input wire logic irq_mask_wr,
    input wire logic [3:0] irq_clear,
    output logic [3:0] irq_status_q,
    output logic [3:0] irq_mask_q,
    output logic host_irq,
    output logic card_irq,
    // autoconfiguration straps
    input pcio_cfg_type cfg_straps,
    output pcio_cfg_type cfg_q
);
    logic [7:0] prn_stat_q;
    logic [1:0] owner_q;
    logic cfg_pend_q;
    logic kbd_busy;
    logic mse_busy;

    // printer port: data and control written, status read back only
    // no physical printer pins exist, registers are virtual
    wire prn_acc = prn_req.wr || prn_req.rd;
    wire prn_wr_data = prn_req.wr && (prn_req.idx == PCIO_PRN_DATA);
    wire prn_wr_ctrl = prn_req.wr && (prn_req.idx == PCIO_PRN_CTRL);
    // direction bit (5) forced to zero: output transfers only
    wire [7:0] prn_ctrl_w = {2'b00, 1'b0, prn_req.wdata[4:0]};
    wire [7:0] prn_rd_mux =
        (prn_req.idx == PCIO_PRN_DATA) ? host_prn_data_q :
        (prn_req.idx == PCIO_PRN_STAT) ? prn_stat_q :
        (prn_req.idx == PCIO_PRN_CTRL) ? host_prn_ctrl_q : 8'hff;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            host_prn_data_q <= 8'h00;
            host_prn_ctrl_q <= PCIO_PRN_CTRL_RST;
            prn_stat_q <= PCIO_PRN_STAT_RST;
            prn_rdata_q <= 8'h00;
        end else begin
            if (prn_wr_data) begin
                host_prn_data_q <= prn_req.wdata;
            end
            if (prn_wr_ctrl) begin
                host_prn_ctrl_q <= prn_ctrl_w;
            end
            if (prn_req.rd) begin
                prn_rdata_q <= prn_rd_mux;
            end
        end
    end

    // keyboard and mouse: one transmitter instance per channel, same module for both
    wire kbd_start = key_in.valid && !key_in.chan && !kbd_busy;
    wire mse_start = key_in.valid && key_in.chan && !mse_busy;
    assign key_ready = key_in.chan ? !mse_busy : !kbd_busy;
    wire key_taken = kbd_start || mse_start;

    pcio_ser_tx u_kbd (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(kbd_start),
        .code(key_in.code),
        .busy(kbd_busy),
        .ser_clk_q(kbd_clk_q),
        .ser_dat_q(kbd_dat_q)
    );

    pcio_ser_tx u_mse (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(mse_start),
        .code(key_in.code),
        .busy(mse_busy),
        .ser_clk_q(mse_clk_q),
        .ser_dat_q(mse_dat_q)
    );

    // mailbox arbitration; card wins a same-cycle tie while idle
    wire idle = (owner_q == PCIO_OWN_NONE);
    wire grant_card = idle && card_req;
    wire grant_host = idle && host_req && !card_req;
    assign card_grant = (owner_q == PCIO_OWN_CARD);
    assign host_grant = (owner_q == PCIO_OWN_HOST);
    // writes from the side without the grant are dropped
    wire cw = card_grant && card_wr;
    wire hw = host_grant && host_wr;
    wire mbx_wr = cw || hw;
    wire [1:0] mbx_sel = cw ? card_sel : host_sel;
    wire [31:0] mbx_wdata = cw ? card_wdata : host_wdata;
    wire cmd_from_card = cw && (card_sel == 2'h2);
    wire cmd_from_host = hw && (host_sel == 2'h2);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            owner_q <= PCIO_OWN_NONE;
            mbx_data_q <= 64'h0;
            mbx_cmd_q <= 32'h0;
        end else begin
            if (grant_card) begin
                owner_q <= PCIO_OWN_CARD;
            end else if (grant_host) begin
                owner_q <= PCIO_OWN_HOST;
            end else if ((card_grant && card_release) || (host_grant && host_release)) begin
                owner_q <= PCIO_OWN_NONE;
            end
            // two 32-bit data words and one 32-bit command word
            if (mbx_wr && mbx_sel == 2'h0) begin
                mbx_data_q[31:0] <= mbx_wdata;
            end
            if (mbx_wr && mbx_sel == 2'h1) begin
                mbx_data_q[63:32] <= mbx_wdata;
            end
            if (mbx_wr && mbx_sel == 2'h2) begin
                mbx_cmd_q <= mbx_wdata;
            end
        end
    end

    // sticky status; a new event wins over a clear in the same cycle
    logic [3:0] irq_event;
    always_comb begin
        irq_event = 4'h0;
        irq_event[PCIO_IRQ_PRN] = prn_acc;
        irq_event[PCIO_IRQ_MBX_HOST] = cmd_from_card;
        irq_event[PCIO_IRQ_MBX_CARD] = cmd_from_host;
        irq_event[PCIO_IRQ_KBD] = key_taken;
    end
    wire [3:0] irq_pend = irq_status_q & irq_mask_q;
    wire [3:0] host_srcs = 4'h0 | (4'h1 << PCIO_IRQ_PRN) | (4'h1 << PCIO_IRQ_MBX_HOST)
                         | (4'h1 << PCIO_IRQ_KBD);
    assign host_irq = |(irq_pend & host_srcs);
    assign card_irq = irq_pend[PCIO_IRQ_MBX_CARD];

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            irq_status_q <= 4'h0;
            irq_mask_q <= PCIO_MASK_RST;
        end else begin
            irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
            if (irq_mask_wr) begin
                irq_mask_q <= irq_mask_wdata;
            end
        end
    end

    // autoconfig: straps captured on the first clock after every reset release
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cfg_pend_q <= 1'b1;
            cfg_q <= '0;
        end else if (cfg_pend_q) begin
            cfg_pend_q <= 1'b0;
            cfg_q <= cfg_straps;
        end
    end
endmodule

// ### verif/pcio_kbc_model.sv
// receiving end of one emulated keyboard or mouse serial line
`timescale 1ns/1ps
module pcio_kbc_model (
    input wire logic ser_clk,
    input wire logic ser_dat,
    output logic [7:0] code = '0,
    output logic frame_ok = '0,
    output int frames = 0
);
    logic [10:0] sh = '0;
    int nbit = 0;
    // bits are taken on the falling clock edge, start bit first
    always @(negedge ser_clk) begin
        sh = {ser_dat, sh[10:1]};
        nbit++;
        if (nbit == 11) begin
            // start low, stop high, odd parity over data plus parity bit
            code = sh[8:1];
            frame_ok = !sh[0] && sh[10] && ^sh[9:1];
            frames++;
            nbit = 0;
        end
    end
endmodule

// ### verif/pcio_checker.sv
// concurrent checks on the pc i/o emulation ports
`timescale 1ns/1ps
module pcio_checker
    import pcio_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input pcio_prn_req_type prn_req,
    input logic [7:0] prn_rdata_q,
    input logic [7:0] host_prn_data_q,
    input pcio_key_type key_in,
    input logic key_ready,
    input logic kbd_dat_q,
    input wire logic card_req,
    input wire logic card_wr,
    input wire logic [1:0] card_sel,
    input wire logic [31:0] card_wdata,
    input logic card_grant,
    input logic host_grant,
    input logic [31:0] mbx_cmd_q,
    input logic [3:0] irq_status_q,
    input logic [3:0] irq_mask_q,
    input logic host_irq,
    input logic card_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_prn_acc_irq: assert property ((prn_req.wr || prn_req.rd) |=> irq_status_q[0])
        else $error("printer access left no interrupt");
    a_stat_read: assert property (prn_req.rd && prn_req.idx == PCIO_PRN_STAT
        |=> prn_rdata_q == PCIO_PRN_STAT_RST) else $error("status read wrong");
    a_data_out: assert property (prn_req.wr && prn_req.idx == PCIO_PRN_DATA
        |=> host_prn_data_q == $past(prn_req.wdata)) else $error("printer data lost");
    a_grant_one: assert property (!(card_grant && host_grant))
        else $error("both sides granted");
    a_grant_req: assert property (card_req && !card_grant && !host_grant |=> card_grant)
        else $error("idle request not granted");
    a_cmd_irq: assert property (card_grant && card_wr && card_sel == 2'h2
        |=> irq_status_q[1] && mbx_cmd_q == $past(card_wdata)) else $error("cmd not signalled");
    a_key_start: assert property (key_in.valid && key_ready && !key_in.chan
        |=> !kbd_dat_q && irq_status_q[3]) else $error("no start bit");
    a_irq_out: assert property (host_irq == |(irq_status_q & irq_mask_q & 4'hb)
        && card_irq == (irq_status_q[2] && irq_mask_q[2])) else $error("irq line wrong");
    c_key: cover property (key_in.valid && key_ready);
    c_cmd: cover property (card_grant && card_wr && card_sel == 2'h2);
    c_host: cover property ($rose(host_grant));
endmodule
bind pcio_top pcio_checker u_chk (.*);

// ### verif/pc_io_emulation_mailbox_test.sv
// self-checking bench for the pc i/o emulation block
`timescale 1ns/1ps
module pc_io_emulation_mailbox_test;
    import pcio_pkg::*;
    logic mclk = '0, reset_n = '0, card_req = '0, card_release = '0, card_wr = '0;
    logic host_req = '0, host_release = '0, host_wr = '0, irq_mask_wr = '0;
    logic [1:0] card_sel = '0, host_sel = '0;
    logic [31:0] card_wdata = '0, host_wdata = '0, a, b, c, mbx_cmd_q;
    logic [3:0] irq_mask_wdata = '0, irq_clear = '0, irq_status_q, irq_mask_q;
    logic [7:0] prn_rdata_q, host_prn_data_q, host_prn_ctrl_q, d, k_code, m_code;
    logic [63:0] mbx_data_q;
    logic key_ready, kbd_clk_q, kbd_dat_q, mse_clk_q, mse_dat_q;
    logic card_grant, host_grant, host_irq, card_irq, k_ok, m_ok;
    pcio_prn_req_type prn_req = '0;
    pcio_key_type key_in = '0;
    pcio_cfg_type cfg_straps = '0, cfg_q;
    int n_fail = 0, comparisons = 0, k_n, m_n, key_q[$];
    pcio_top i_dut (.*);
    pcio_kbc_model i_kbd (.ser_clk(kbd_clk_q), .ser_dat(kbd_dat_q), .code(k_code),
        .frame_ok(k_ok), .frames(k_n));
    pcio_kbc_model i_mse (.ser_clk(mse_clk_q), .ser_dat(mse_dat_q), .code(m_code),
        .frame_ok(m_ok), .frames(m_n));
    task automatic chk(logic [63:0] got, logic [63:0] exp, string msg);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic prn(logic w, logic [1:0] i, logic [7:0] v);
        @(posedge mclk) prn_req <= '{w, !w, i, v};
        @(posedge mclk) prn_req <= '0;
        #1;
    endtask
    task automatic mbx(logic h, logic [1:0] s, logic [31:0] v);
        @(posedge mclk);
        if (h) {host_wr, host_sel, host_wdata} <= {1'b1, s, v};
        else {card_wr, card_sel, card_wdata} <= {1'b1, s, v};
        @(posedge mclk) {host_wr, card_wr} <= '0;
        #1;
    endtask
    task automatic irq(logic m, logic [3:0] v);
        @(posedge mclk) {irq_mask_wr, irq_mask_wdata, irq_clear} <= m ? {1'b1, v, 4'h0} : {5'h00, v};
        @(posedge mclk) {irq_mask_wr, irq_clear} <= '0;
        #1;
    endtask
    initial forever #25 mclk = ~mclk;
    initial begin
        void'($urandom(32'h25ecf0a8));
        cfg_straps = 13'($urandom);
        repeat (20) @(posedge mclk);
        reset_n <= '1;
        @(posedge mclk) #1;
        chk(cfg_q, cfg_straps, "cfg");
        irq('1, 4'hf);
        chk(irq_mask_q, 4'hf, "mask");
        prn('0, PCIO_PRN_STAT, '0);
        chk({prn_rdata_q, host_irq}, {PCIO_PRN_STAT_RST, 1'b1}, "stat");
        prn('1, PCIO_PRN_STAT, '0);
        prn('0, PCIO_PRN_STAT, '0);
        chk(prn_rdata_q, PCIO_PRN_STAT_RST, "stat wr");
        prn('0, 2'h3, '0);
        chk(prn_rdata_q, 8'hff, "idx3");
        d = 8'($urandom);
        prn('1, PCIO_PRN_DATA, d);
        chk(host_prn_data_q, d, "data");
        prn('1, PCIO_PRN_CTRL, d);
        // direction bit and the two unused top bits always read back low
        chk(host_prn_ctrl_q, d & 8'h1f, "ctrl");
        irq('1, 4'he);
        irq('0, 4'h1);
        prn('0, PCIO_PRN_DATA, '0);
        chk({irq_status_q[0], host_irq}, 2'h2, "masked");
        $display("test printer done");
        @(posedge mclk) {card_req, host_req} <= 2'h3;
        @(posedge mclk) card_req <= '0;
        #1;
        chk({card_grant, host_grant}, 2'h2, "tie");
        a = $urandom;
        b = $urandom;
        c = $urandom;
        mbx('0, 2'h0, a);
        mbx('0, 2'h1, b);
        mbx('1, 2'h0, ~a);
        mbx('0, 2'h2, c);
        chk(mbx_data_q, {b, a}, "mbx data");
        chk({mbx_cmd_q, irq_status_q[1], host_irq}, {c, 2'h3}, "cmd");
        @(posedge mclk) card_release <= '1;
        @(posedge mclk) card_release <= '0;
        @(posedge mclk) host_req <= '0;
        #1;
        chk({card_grant, host_grant}, 2'h1, "handover");
        mbx('0, 2'h2, ~c);
        mbx('1, 2'h2, a);
        chk({mbx_cmd_q, card_irq}, {a, 1'b1}, "to card");
        @(posedge mclk) host_release <= '1;
        @(posedge mclk) host_release <= '0;
        $display("test mailbox done");
        for (int ch = 0; ch < 2; ch++) begin
            key_q.push_back(8'($urandom));
            @(posedge mclk) key_in <= '{1'b1, ch[0], key_q[ch][7:0]};
            @(posedge mclk) key_in <= '0;
            #1;
        end
        chk({key_ready, irq_status_q[3]}, 2'h1, "busy");
        // a missing frame leaves the flags low and fails below
        for (int i = 0; i < 20000 && (k_n < 1 || m_n < 1); i++) @(posedge mclk);
        chk({k_ok, k_code}, {1'b1, key_q[0][7:0]}, "kbd");
        chk({m_ok, m_code}, {1'b1, key_q[1][7:0]}, "mouse");
        chk({k_n[7:0], m_n[7:0]}, 16'h0101, "one frame each");
        $display("test keys done");
        // a second reset must sense the straps again and reset the state
        @(posedge mclk) begin
            reset_n <= '0;
            cfg_straps <= 13'($urandom);
        end
        repeat (2) @(posedge mclk);
        reset_n <= '1;
        @(posedge mclk) #1;
        chk({cfg_q, irq_status_q, host_prn_ctrl_q}, {cfg_straps, 4'h0, PCIO_PRN_CTRL_RST}, "rst");
        chk({card_grant, host_grant, kbd_clk_q, mse_clk_q}, 4'h3, "rst lines");
        $display("test reset done");
        final_report();
    end
endmodule
